//--- src/adc_averager_totalizer.v
// Converter readout: instant sample, per-second averages and 32-bit totals.
`timescale 1ns/1ps
`default_nettype none
`include "adc_totalizer_defs.vh"

module adc_averager_totalizer #(
  parameter SUM_W = 24
) (
  input  wire        clk,          // System clock, 250 MHz
  input  wire        rst_n,        // Async reset, active low
  input  wire        convValid,    // Converter result ready, one cycle
  input  wire [9:0]  convData,     // Converter 10-bit result
  input  wire        secTick,      // One-second boundary pulse
  input  wire [2:0]  prescale,     // Second timer prescale_select
  input  wire [15:0] periodB,      // Second timer period_b
  input  wire [15:0] dutyB,        // Second timer duty_b
  input  wire        pulseIn,      // Shared pulse channel level
  output wire        pinOut,       // Pin drive level
  output wire        pinOe_n,      // Pin output enable, low drives
  input  wire [4:0]  regAddr,      // Register byte address
  input  wire        regWrEn,      // Register write strobe
  input  wire [7:0]  regWrData,    // Register write byte
  input  wire        regRdEn,      // Register read strobe
  output reg  [7:0]  regRdData     // Read byte, valid next cycle
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg  [7:0]  converterConfig;
  reg  [7:0]  instantSample;
  reg  [9:0]  wideSample;
  reg  [31:0] totalPos;
  reg  [31:0] totalNeg;
  wire [15:0] avgPos;
  wire [15:0] avgNeg;
  wire        sumStrobe;

  wire inputEnable = converterConfig[`CFG_ENABLE_BIT];
  wire wideMode    = converterConfig[`CFG_WIDE_BIT];
  wire midOffset   = converterConfig[`CFG_OFFSET_BIT];
  wire groupTotals = converterConfig[`CFG_GROUP_BIT];
  wire totalFreeze = converterConfig[`CFG_FREEZE_BIT];

  // ---------------------------------------------------------------
  // Pin sharing
  // ---------------------------------------------------------------
  // R2 release pin when enabled
  // R3 pulse channel otherwise
  assign pinOut  = inputEnable ? 1'b0 : pulseIn;
  assign pinOe_n = inputEnable;

  // ---------------------------------------------------------------
  // Sample capture
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instantSample <= 8'h00;
      wideSample    <= 10'h000;
    end else if (convValid) begin
      // R1 newest sample always held
      instantSample <= convData[9:2];
      // R4 wide result kept only in wide mode
      if (wideMode) begin
        wideSample <= convData;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sample routing into window sums
  // ---------------------------------------------------------------
  wire [8:0] signedVal = {1'b0, instantSample} - `MIDSCALE;
  wire [7:0] negMag    = 8'h00 - signedVal[7:0];
  reg        addPos;
  reg        addNeg;
  reg  [7:0] posVal;
  reg  [7:0] negVal;

  always @* begin
    addPos = 1'b0;
    addNeg = 1'b0;
    posVal = instantSample;
    negVal = negMag;
    if (!midOffset) begin
      // R5 unsigned into positive only
      addPos = sumStrobe;
    end else begin
      // R6 split around mid-scale
      posVal = signedVal[7:0];
      addPos = sumStrobe && !signedVal[8] && (signedVal[7:0] != 8'h00);
      addNeg = sumStrobe && signedVal[8];
    end
  end

  summation_pacer u_pacer (
    .clk       (clk),
    .rst_n     (rst_n),
    .prescale  (prescale),
    .periodB   (periodB),
    .dutyB     (dutyB),
    .sumStrobe (sumStrobe)
  );

  // R11 two read-only averages
  window_sum #(.SUM_W(SUM_W)) u_sumPos (
    .clk     (clk),
    .rst_n   (rst_n),
    .addEn   (addPos),
    .addVal  (posVal),
    .secTick (secTick),
    .average (avgPos)
  );

  window_sum #(.SUM_W(SUM_W)) u_sumNeg (
    .clk     (clk),
    .rst_n   (rst_n),
    .addEn   (addNeg),
    .addVal  (negVal),
    .secTick (secTick),
    .average (avgNeg)
  );

  // ---------------------------------------------------------------
  // Totals: added one cycle after the tick, once averages are stored
  // ---------------------------------------------------------------
  reg         tickSeen;
  wire        wrTotPos = regWrEn && (regAddr[4:2] == `OFS_TOTPOS_BASE >> 2);
  wire        wrTotNeg = regWrEn && (regAddr[4:2] == `OFS_TOTNEG_BASE >> 2);
  wire [31:0] addP     = groupTotals ? {16'h0000, avgPos} + {16'h0000, avgNeg}
                                     : {16'h0000, avgPos};

  // Byte replace, big endian: lowest address holds bits 31:24
  function [31:0] putByte;
    input [31:0] word;
    input [1:0]  lane;
    input [7:0]  data;
    begin
      putByte = word;
      case (lane)
        2'd0:    putByte[31:24] = data;
        2'd1:    putByte[23:16] = data;
        2'd2:    putByte[15:8]  = data;
        default: putByte[7:0]   = data;
      endcase
    end
  endfunction

  function [7:0] getByte;
    input [31:0] word;
    input [1:0]  lane;
    begin
      case (lane)
        2'd0:    getByte = word[31:24];
        2'd1:    getByte = word[23:16];
        2'd2:    getByte = word[15:8];
        default: getByte = word[7:0];
      endcase
    end
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickSeen <= 1'b0;
      totalPos <= 32'h00000000;
      totalNeg <= 32'h00000000;
    end else begin
      tickSeen <= secTick;
      // R19 write wins over addition
      // R17 big-endian byte lanes
      if (wrTotPos) begin
        totalPos <= putByte(totalPos, regAddr[1:0], regWrData);
      // R8 freeze holds totals
      // R10 per-second advance
      end else if (tickSeen && !totalFreeze) begin
        // R7 group adds both averages
        totalPos <= totalPos + addP;
      end
      if (wrTotNeg) begin
        totalNeg <= putByte(totalNeg, regAddr[1:0], regWrData);
      end else if (tickSeen && !totalFreeze && !groupTotals) begin
        totalNeg <= totalNeg + {16'h0000, avgNeg};
      end
    end
  end

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      converterConfig <= `CFG_RESET;
    end else if (regWrEn && (regAddr == `OFS_CONFIG)) begin
      converterConfig <= regWrData & `CFG_WRITE_MASK;
    end
  end

  // Read-only registers ignore writes; unmapped bytes read zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      case (regAddr)
        `OFS_CONFIG:    regRdData <= converterConfig;
        `OFS_INSTANT:   regRdData <= instantSample;
        `OFS_WIDE_HI:   regRdData <= {6'h00, wideSample[9:8]};
        `OFS_WIDE_LO:   regRdData <= wideSample[7:0];
        `OFS_AVGPOS_HI: regRdData <= avgPos[15:8];
        `OFS_AVGPOS_LO: regRdData <= avgPos[7:0];
        `OFS_AVGNEG_HI: regRdData <= avgNeg[15:8];
        `OFS_AVGNEG_LO: regRdData <= avgNeg[7:0];
        default: begin
          if (regAddr[4:2] == `OFS_TOTPOS_BASE >> 2) begin
            regRdData <= getByte(totalPos, regAddr[1:0]);
          end else if (regAddr[4:2] == `OFS_TOTNEG_BASE >> 2) begin
            regRdData <= getByte(totalNeg, regAddr[1:0]);
          end else begin
            regRdData <= 8'h00;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- src/adc_totalizer_defs.vh
// Offsets, field positions, reset values and timing figures for the averager.
// What this block does
// R1: Keep newest 8-bit sample for instant reads.
// R2: Input enable (value 16) releases pin, stops pulses.
// R3: Enable clear: pulse channel drives pin, sampling continues.
// R4: Wide mode stores 10-bit result in wide register.
// R5: No offset: unsigned samples feed positive sum only.
// R6: Offset: subtract 128, split positive and negative.
// R7: Group bit: positive total takes both averages.
// R8: Freeze bit holds totals, averages keep updating.
// R9: 24-bit sum divided by 64 each second.
// R10: Two 32-bit totals, read/write, advanced per second.
// R11: Averages 16-bit, read-only, last completed window.
// R12: Stored average keeps bits 21:6 of the 24-bit sum.
// R13: Rate is prescaled timer clock over period.
// R14: Duty picks sample instant; zero or excess suppresses.
// R15: Software keeps rate under 4096 when enabled.
// R16: Three-bit prescaler selects eight power-of-two divisors.
// R17: Multi-byte registers are big endian.
// R18: Window sums cleared after each transfer.
// R19: Software total write beats per-second addition.
`ifndef ADC_TOTALIZER_DEFS_VH
`define ADC_TOTALIZER_DEFS_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_CONFIG        5'h00
`define OFS_INSTANT       5'h01
`define OFS_WIDE_HI       5'h02
`define OFS_WIDE_LO       5'h03
`define OFS_AVGPOS_HI     5'h04
`define OFS_AVGPOS_LO     5'h05
`define OFS_AVGNEG_HI     5'h06
`define OFS_AVGNEG_LO     5'h07
`define OFS_TOTPOS_BASE   5'h08
`define OFS_TOTNEG_BASE   5'h0c

// ---------------------------------------------------------------
// Configuration fields and reset values
// ---------------------------------------------------------------
`define CFG_FREEZE_BIT    0
`define CFG_GROUP_BIT     1
`define CFG_OFFSET_BIT    2
`define CFG_WIDE_BIT      3
`define CFG_ENABLE_BIT    4
`define CFG_WRITE_MASK    8'h1f
`define CFG_RESET         8'h00
`define MIDSCALE          9'h080
`define AVG_SHIFT         6

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_MHZ           250
`define TPM_CLK_MHZ       16

`endif

//--- src/summation_pacer.v
// Sample strobe generator paced by the second timer's prescaler, period and duty.
`timescale 1ns/1ps
`default_nettype none
`include "adc_totalizer_defs.vh"

module summation_pacer #(
  parameter CLK_MHZ = `CLK_MHZ,
  parameter TPM_MHZ = `TPM_CLK_MHZ
) (
  input  wire        clk,          // System clock
  input  wire        rst_n,        // Async reset, active low
  input  wire [2:0]  prescale,     // prescale_select field
  input  wire [15:0] periodB,      // period_b value
  input  wire [15:0] dutyB,        // duty_b value
  output reg         sumStrobe     // One-cycle strobe: take a sample
);

  localparam [8:0] STEP = TPM_MHZ[8:0];
  localparam [8:0] WRAP = CLK_MHZ[8:0];

  // ---------------------------------------------------------------
  // Divisor mask decode
  // ---------------------------------------------------------------
  function [6:0] divMask;
    input [2:0] sel;
    begin
      divMask = (7'h01 << sel) - 7'h01;
    end
  endfunction

  reg  [8:0]  phase;
  reg  [6:0]  preCnt;
  reg  [15:0] perCnt;
  wire [8:0]  phaseSum = phase + STEP;
  // Fractional accumulator: the timer clock is not an integer fraction of clk
  wire        tpmTick  = (phaseSum >= WRAP);
  // R16 power-of-two divide
  wire        divTick  = tpmTick && ((preCnt & divMask(prescale)) == divMask(prescale));
  // R14 duty gating
  wire        dutyOk   = (dutyB != 16'h0000) && (dutyB <= periodB);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase     <= 9'h000;
      preCnt    <= 7'h00;
      perCnt    <= 16'h0001;
      sumStrobe <= 1'b0;
    end else begin
      phase     <= tpmTick ? phaseSum - WRAP : phaseSum;
      sumStrobe <= 1'b0;
      if (tpmTick) begin
        preCnt <= preCnt + 7'h01;
      end
      if (divTick) begin
        // R13 rate is divided clock over period
        if (perCnt >= periodB) begin
          perCnt <= 16'h0001;
        end else begin
          perCnt <= perCnt + 16'h0001;
        end
        sumStrobe <= dutyOk && (perCnt == dutyB);
      end
    end
  end

endmodule
`default_nettype wire

//--- src/window_sum.v
// One-second summation window producing a scaled average.
`timescale 1ns/1ps
`default_nettype none
`include "adc_totalizer_defs.vh"

module window_sum #(
  parameter SUM_W = 24
) (
  input  wire        clk,       // System clock
  input  wire        rst_n,     // Async reset, active low
  input  wire        addEn,     // Add addVal this cycle
  input  wire [7:0]  addVal,    // Sample magnitude
  input  wire        secTick,   // One-second boundary pulse
  output reg  [15:0] average    // Last completed window average
);

  reg  [SUM_W-1:0] sum;
  wire [SUM_W-1:0] addExt = {{(SUM_W-8){1'b0}}, addVal};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sum     <= {SUM_W{1'b0}};
      average <= 16'h0000;
    end else if (secTick) begin
      // R9 divide by 64
      // R12 keeps sum bits 21:6
      average <= sum[`AVG_SHIFT+15:`AVG_SHIFT];
      // R18 restart window; a coincident sample opens the next one
      sum     <= addEn ? addExt : {SUM_W{1'b0}};
    end else if (addEn) begin
      sum     <= sum + addExt;
    end
  end

endmodule
`default_nettype wire

//--- tb/adc_averager_totalizer_properties.sv
// Port checker for the converter readout block.
`timescale 1ns/1ps
`default_nettype none
module adc_averager_totalizer_properties (
  input wire       clk,       // Clock
  input wire       rst_n,     // Reset
  input wire       convValid, // Result strobe
  input wire [9:0] convData,  // Result
  input wire       pulseIn,   // Pulse level
  input wire       pinOut,    // Pin drive
  input wire       pinOe_n,   // Pin enable
  input wire [4:0] regAddr,   // Address
  input wire       regWrEn,   // Write strobe
  input wire [7:0] regWrData, // Write byte
  input wire       regRdEn,   // Read strobe
  input wire [7:0] regRdData  // Read byte
);
  reg [9:0] lastConv;
  reg [9:0] lastWide;
  reg       wideOn;

  // Newest result, as the register port should present it; wide copy only in wide mode
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lastConv <= 10'h000;
      lastWide <= 10'h000;
      wideOn   <= 1'b0;
    end else begin
      if (convValid) begin
        lastConv <= convData;
      end
      if (convValid && wideOn) begin
        lastWide <= convData;
      end
      if (regWrEn && regAddr == 5'h00) begin
        wideOn <= regWrData[3];
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_pin_follow: assert property (!pinOe_n |-> pinOut == pulseIn)
    else $error("pin not following pulse channel");
  a_pin_quiet: assert property (pinOe_n |-> !pinOut)
    else $error("released pin still driven");
  a_enable_write: assert property (regWrEn && regAddr == 5'h00
    |=> pinOe_n == $past(regWrData[4]))
    else $error("pin enable not taken from config");
  a_instant_read: assert property (regRdEn && regAddr == 5'h01
    |=> regRdData == $past(lastConv[9:2]))
    else $error("instant sample not newest");
  a_wide_low: assert property (regRdEn && regAddr == 5'h03
    |=> regRdData == $past(lastWide[7:0]))
    else $error("wide sample low byte wrong");
  a_wide_high: assert property (regRdEn && regAddr == 5'h02
    |=> regRdData == {6'h00, $past(lastWide[9:8])})
    else $error("wide sample high byte wrong");
  a_cfg_mask: assert property (regWrEn && regAddr == 5'h00 ##1
    regRdEn && !regWrEn && regAddr == 5'h00 |=> regRdData == ($past(regWrData, 2) & 8'h1f))
    else $error("config readback wrong");
  a_unmapped_zero: assert property (regRdEn && regAddr[4] |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_read_stands: assert property (!regRdEn |=> $stable(regRdData))
    else $error("read data changed without a read");

  c_released_read: cover property (pinOe_n && regRdEn && regAddr == 5'h01);
  c_unmapped: cover property (regRdEn && regAddr[4]);
  c_total_write: cover property (regWrEn && regAddr == 5'h0b);
endmodule

bind adc_averager_totalizer adc_averager_totalizer_properties i_props (.clk, .rst_n, .convValid,
  .convData, .pulseIn, .pinOut, .pinOe_n, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData);
`default_nettype wire

//--- tb/analog_source.sv
// Voltage source and converter model on the shared input pin.
`timescale 1ns/1ps
`default_nettype none
module analog_source (
  input  wire       clk,       // System clock
  input  wire       rst_n,     // Reset, active low
  input  wire [9:0] level,     // Applied voltage code
  input  wire       pinOut,    // Device pin drive
  input  wire       pinOe_n,   // Low while device drives
  output reg        convValid, // One-cycle result strobe
  output reg  [9:0] convData   // Converted pin voltage
);
  reg  [3:0] phase;
  wire [9:0] pinLevel;

  assign pinLevel = pinOe_n ? level : {10{pinOut}};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase     <= 4'h0;
      convValid <= 1'b0;
      convData  <= 10'h000;
    end else begin
      phase     <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
      convValid <= (phase == 4'h9);
      convData  <= pinLevel;
    end
  end
endmodule
`default_nettype wire

//--- tb/adc_averager_totalizer_tb_top.sv
// Self-checking bench for the converter readout block.
`timescale 1ns/1ps
`default_nettype none
module adc_averager_totalizer_tb_top;
  typedef struct packed {
    logic [7:0]  cfg;
    logic [3:0]  ps;
    logic [7:0]  per;
    logic [7:0]  duty;
    logic [11:0] lvl;
    logic [3:0]  pls;
    logic [7:0]  ap;
    logic [7:0]  an;
    logic [7:0]  dp;
    logic [7:0]  dn;
  } row_t;
  // sixteen sums per window at most
  row_t rows [14] = '{
    76'h10_0_08_01_200_0_20_00_20_00, 76'h10_3_01_01_3fc_0_3f_00_3f_00,
    76'h14_1_04_02_240_0_04_00_04_00, 76'h14_2_02_02_1c0_0_00_04_00_04,
    76'h16_0_08_08_1c0_0_00_04_04_00, 76'h11_0_08_01_200_0_20_00_00_00,
    76'h10_0_08_00_200_0_00_00_00_00, 76'h10_0_08_09_200_0_00_00_00_00,
    76'h14_0_08_01_200_0_00_00_00_00, 76'h10_4_01_01_200_0_10_00_10_00,
    76'h10_5_01_01_200_0_08_00_08_00, 76'h10_6_01_01_200_0_04_00_04_00,
    76'h10_7_01_01_200_0_02_00_02_00, 76'h00_0_08_01_000_1_3f_00_3f_00};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        secTick = 1'b0;
  logic [2:0]  prescale = 3'h0;
  logic [15:0] periodB = 16'h0008;
  logic [15:0] dutyB = 16'h0001;
  logic        pulseIn = 1'b0;
  logic [9:0]  level = 10'h000;
  logic [4:0]  regAddr = 5'h00;
  logic        regWrEn = 1'b0;
  logic [7:0]  regWrData = 8'h00;
  logic        regRdEn = 1'b0;
  wire         convValid;
  wire  [9:0]  convData;
  wire         pinOut;
  wire         pinOe_n;
  wire  [7:0]  regRdData;
  int          errors = 0;
  int          comparisons = 0;
  logic [31:0] d;
  logic [31:0] tp;
  logic [31:0] tn;

  always #2 clk = ~clk;

  adc_averager_totalizer i_dut (.clk, .rst_n, .convValid, .convData, .secTick, .prescale,
    .periodB, .dutyB, .pulseIn, .pinOut, .pinOe_n, .regAddr, .regWrEn, .regWrData, .regRdEn,
    .regRdData);
  analog_source i_src (.clk, .rst_n, .level, .pinOut, .pinOe_n, .convValid, .convData);

  // ------
  // Tasks
  // ------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Strobes stay up between back-to-back calls, so none is set twice in one step
  task automatic idle(input logic t, input int n);
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    secTick = t;
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    regRdEn = 1'b0;
    secTick = 1'b0;
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = v;
    @(negedge clk);
  endtask

  task automatic rd(input logic [4:0] a, input int n, output logic [31:0] v);
    v = '0;
    for (int k = 0; k < n; k++) begin
      regWrEn = 1'b0;
      secTick = 1'b0;
      regRdEn = 1'b1;
      regAddr = a + k[4:0];
      @(negedge clk);
      v = {v[23:0], regRdData};
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ------
  // Main sequence
  // ------
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    for (int a = 0; a < 32; a++) begin
      rd(a[4:0], 1, d);
      chk("reset read", d, 32'h0); // cleared at reset
    end
    wr(5'h04, 8'haa);
    wr(5'h00, 8'hff);
    rd(5'h00, 1, d);
    chk("config mask", d, 32'h1f); // writable bits
    level = 10'h2a7;
    for (int k = 0; k < 4; k++) begin
      wr(5'h08 + k[4:0], 8'h12 + 8'h22 * k[7:0]);
    end
    idle(0, 20);
    rd(5'h04, 1, d);
    chk("read-only average", d, 32'h0); // write ignored
    rd(5'h08, 4, d);
    chk("total bytes", d, 32'h12345678); // high byte first
    rd(5'h02, 2, d);
    chk("wide sample", d, 32'h2a7); // ten bits
    rd(5'h01, 1, d);
    chk("instant sample", d, 32'ha9); // newest sample
    $display("register tests done");
    foreach (rows[i]) begin
      wr(5'h00, rows[i].cfg);
      prescale = rows[i].ps[2:0];
      periodB = {8'h00, rows[i].per};
      dutyB = {8'h00, rows[i].duty};
      level = rows[i].lvl[9:0];
      pulseIn = rows[i].pls[0];
      // Long enough for one divided tick at divisor 16, so the period counter settles
      idle(0, 260);
      idle(1, 1);
      idle(0, 1991);
      rd(5'h08, 4, tp);
      rd(5'h0c, 4, tn);
      idle(1, 1);
      idle(0, 3);
      rd(5'h04, 2, d);
      chk("average positive", d, rows[i].ap); // scaling
      rd(5'h06, 2, d);
      chk("average negative", d, rows[i].an); // signed split
      rd(5'h08, 4, d);
      chk("total positive", d, tp + rows[i].dp); // totals
      rd(5'h0c, 4, d);
      chk("total negative", d, tn + rows[i].dn); // totals
      $display("row %0d done", i);
    end
    idle(0, 1980);
    rd(5'h08, 4, tp);
    idle(1, 1);
    wr(5'h0b, 8'h55);
    idle(0, 3);
    rd(5'h08, 4, d);
    chk("total write priority", d, {tp[31:8], 8'h55}); // written byte kept
    $display("priority test done");
    wr(5'h00, 8'h13);
    idle(0, 2);
    chk("pin released", {31'h0, pinOe_n}, 32'h1); // enable releases pin
    rst_n = 1'b0;
    idle(0, 4);
    chk("pin after reset", {31'h0, pinOe_n}, 32'h0); // pulse channel drives
    rst_n = 1'b1;
    rd(5'h00, 1, d);
    chk("config after reset", d, 32'h0); // enable cleared
    rd(5'h08, 4, d);
    chk("total after reset", d, 32'h0); // totals cleared
    $display("mid-run reset test done");
    test_done;
  end
endmodule
`default_nettype wire
